// >>> inc/dcap_pkg.sv
// constants and types for the debug control access port
// assumes one core clock domain; debugger requests arrive on a slow link
//
// Behaviour
// - debugger reset write requests system soft reset unless an erase runs
// - debugger-caused soft reset recorded as reset cause
// - debugger erase write starts full chip erase
// - erase progress flag busy throughout erase
// - erase ends: config unprotected, CPU keys loaded
// - unprotection starts next soft reset, ends hard
// - secondary erase clears application MCU first
// - erase protection refuses debugger erase after reset
// - no port protection: equal nonzero port keys allow debugger memory access
// - mailbox flags changed only by data accesses
// - word write sets that direction's flag; word read clears it
// - equal nonzero erase keys start full erase
// - key-triggered erase reopens ports next soft reset
// - erase guard latch write-once, blocks unlock
// - configured port protection keeps port protected
// - equal nonzero port keys open non-secure debug
// - port guard latch write-once, blocks unlock
// - equal nonzero secure keys open secure debug
// - secure guard latch write-once, blocks unlock
// - secure debug on: erase keys start erase
// - port and secure keys survive soft reset
// - protection blocks debugger bus access port
package dcap_pkg;
  localparam int AW = 12;
  localparam int DW = 32;
  // debugger side offsets
  localparam logic [AW-1:0] DBG_SOFT_RST_OFS   = 12'h000;
  localparam logic [AW-1:0] DBG_ERASE_OFS      = 12'h004;
  localparam logic [AW-1:0] DBG_ERASE_STAT_OFS = 12'h008;
  localparam logic [AW-1:0] DBG_PORT_KEY_OFS   = 12'h010;
  localparam logic [AW-1:0] DBG_SEC_KEY_OFS    = 12'h014;
  localparam logic [AW-1:0] DBG_EP_STAT_OFS    = 12'h018;
  localparam logic [AW-1:0] DBG_EP_KEY_OFS     = 12'h01C;
  localparam logic [AW-1:0] DBG_OUT_WORD_OFS   = 12'h020;
  localparam logic [AW-1:0] DBG_OUT_FLAG_OFS   = 12'h024;
  localparam logic [AW-1:0] DBG_IN_WORD_OFS    = 12'h028;
  localparam logic [AW-1:0] DBG_IN_FLAG_OFS    = 12'h02C;
  localparam logic [AW-1:0] DBG_IDENT_OFS      = 12'h0FC;
  // cpu side offsets
  localparam logic [AW-1:0] CPU_IN_WORD_OFS    = 12'h400;
  localparam logic [AW-1:0] CPU_IN_FLAG_OFS    = 12'h404;
  localparam logic [AW-1:0] CPU_OUT_WORD_OFS   = 12'h480;
  localparam logic [AW-1:0] CPU_OUT_FLAG_OFS   = 12'h484;
  localparam logic [AW-1:0] CPU_EP_LATCH_OFS   = 12'h500;
  localparam logic [AW-1:0] CPU_EP_KEY_OFS     = 12'h504;
  localparam logic [AW-1:0] CPU_PORT_LATCH_OFS = 12'h540;
  localparam logic [AW-1:0] CPU_PORT_KEY_OFS   = 12'h544;
  localparam logic [AW-1:0] CPU_SEC_LATCH_OFS  = 12'h548;
  localparam logic [AW-1:0] CPU_SEC_KEY_OFS    = 12'h54C;
  localparam logic [AW-1:0] CPU_STATUS_OFS     = 12'h600;
  // status field positions
  localparam int STAT_PORT_BIT = 0;
  localparam int STAT_SEC_BIT  = 1;
  localparam int STAT_EP_BIT   = 2;
  // values
  localparam logic [DW-1:0] KEY_AFTER_ERASE = 32'h50FA50FA;
  localparam logic [DW-1:0] WORD_RST        = 32'h00000000;
  localparam logic          GUARD_RST       = 1'b1;
  typedef enum logic [1:0] {
    ER_IDLE   = 2'b00,
    ER_APP    = 2'b01,
    ER_LOCAL  = 2'b10,
    ER_FINISH = 2'b11
  } dcap_erase_e;
endpackage : dcap_pkg

// >>> rtl/dcap_top.sv
// debug control access port: soft reset, erase, mailbox, port unlock
// debugger requests come from a serial engine on its own link clock;
// cpu requests are synchronous to core_clk_i
`timescale 1ns/1ns
`default_nettype none
module dcap_top
  import dcap_pkg::*;
#(
  parameter logic            IS_SECONDARY = 1'b0,
  parameter logic [DW-1:0]   IDENT_VALUE  = 32'h00A50001 // arbitrary
)(
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          pin_rst_i,
  input  wire logic          soft_rst_i,
  input  wire logic [AW-1:0] cpu_addr_i,
  input  wire logic [DW-1:0] cpu_wdata_i,
  input  wire logic          cpu_wr_i,
  input  wire logic          cpu_rd_i,
  output logic      [DW-1:0] cpu_rdata_o,
  input  wire logic          dbg_clk_i,
  input  wire logic [AW-1:0] dbg_addr_i,
  input  wire logic [DW-1:0] dbg_wdata_i,
  input  wire logic          dbg_wr_i,
  input  wire logic          dbg_rd_i,
  output logic      [DW-1:0] dbg_rdata_o,
  input  wire logic          cfg_port_prot_i,
  input  wire logic          cfg_sec_prot_i,
  input  wire logic          cfg_erase_prot_i,
  input  wire logic          erase_done_i,
  input  wire logic          app_erase_done_i,
  output logic               soft_rst_req_o,
  output logic               rst_cause_dbg_o,
  output logic               erase_req_o,
  output logic               app_erase_req_o,
  output logic               cfg_unprot_wr_o,
  output logic               erase_busy_o,
  output logic               bus_ap_en_o,
  output logic               bus_sec_ap_en_o
);

  function automatic logic key_ok(input logic [DW-1:0] a,
                                  input logic [DW-1:0] b);
    key_ok = (a == b) && (a != WORD_RST);
  endfunction : key_ok

  logic full_rst;
  logic any_rst;
  assign full_rst = sys_rst_i | pin_rst_i;
  assign any_rst  = full_rst | soft_rst_i;

  // link side synchronisers
  logic          dck_s1_r, dck_s2_r, dck_s3_r;
  logic [AW-1:0] dad_s1_r, dad_s2_r;
  logic [DW-1:0] dwd_s1_r, dwd_s2_r;
  logic          dwr_s1_r, dwr_s2_r, drd_s1_r, drd_s2_r;
  always_ff @(posedge core_clk_i)
  begin
    dck_s1_r <= dbg_clk_i;
    dck_s2_r <= dck_s1_r;
    dck_s3_r <= dck_s2_r;
    dad_s1_r <= dbg_addr_i;
    dad_s2_r <= dad_s1_r;
    dwd_s1_r <= dbg_wdata_i;
    dwd_s2_r <= dwd_s1_r;
    dwr_s1_r <= dbg_wr_i;
    dwr_s2_r <= dwr_s1_r;
    drd_s1_r <= dbg_rd_i;
    drd_s2_r <= drd_s1_r;
  end

  logic dck_rise, dbg_wr_ev, dbg_rd_ev;
  assign dck_rise  = dck_s2_r & ~dck_s3_r;
  assign dbg_wr_ev = dck_rise & dwr_s2_r;
  assign dbg_rd_ev = dck_rise & drd_s2_r & ~dwr_s2_r;

  logic cw, cr;
  assign cw = cpu_wr_i;
  assign cr = cpu_rd_i;

  // configuration captured once after every reset
  logic cap_pend_r, port_cap_r, sec_cap_r, ep_cap_r;
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
    begin
      cap_pend_r <= 1'b1;
      port_cap_r <= GUARD_RST;
      sec_cap_r  <= GUARD_RST;
      ep_cap_r   <= GUARD_RST;
    end
    else if (cap_pend_r)
    begin
      cap_pend_r <= 1'b0;
      port_cap_r <= cfg_port_prot_i;
      sec_cap_r  <= cfg_sec_prot_i;
      ep_cap_r   <= cfg_erase_prot_i;
    end
  end

  // write-once guard latches, cleared by any reset
  logic ep_latch_r, port_latch_r, sec_latch_r;
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
    begin
      ep_latch_r   <= 1'b0;
      port_latch_r <= 1'b0;
      sec_latch_r  <= 1'b0;
    end
    else if (cw)
    begin
      if (cpu_addr_i == CPU_EP_LATCH_OFS)
        ep_latch_r <= ep_latch_r | cpu_wdata_i[0];
      if (cpu_addr_i == CPU_PORT_LATCH_OFS)
        port_latch_r <= port_latch_r | cpu_wdata_i[0];
      if (cpu_addr_i == CPU_SEC_LATCH_OFS)
        sec_latch_r <= sec_latch_r | cpu_wdata_i[0];
    end
  end

  // erase sequencer
  dcap_erase_e erase_st_r, erase_nxt;
  logic        erase_start;
  logic [DW-1:0] ep_key_dbg_r, ep_key_cpu_r;
  logic        ep_key_hit;
  assign ep_key_hit = key_ok(ep_key_dbg_r, ep_key_cpu_r) & ~ep_latch_r
                      & (ep_cap_r | bus_sec_ap_en_o);
  assign erase_start = (erase_st_r == ER_IDLE) & (ep_key_hit |
    (dbg_wr_ev & (dad_s2_r == DBG_ERASE_OFS) & ~ep_cap_r));

  always_comb
  begin
    erase_nxt = erase_st_r;
    case (erase_st_r)
      ER_IDLE:
        if (erase_start)
          erase_nxt = IS_SECONDARY ? ER_APP : ER_LOCAL;
      ER_APP:
        if (app_erase_done_i)
          erase_nxt = ER_LOCAL;
      ER_LOCAL:
        if (erase_done_i)
          erase_nxt = ER_FINISH;
      ER_FINISH:
        erase_nxt = ER_IDLE;
      default:
        erase_nxt = ER_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (full_rst)
    begin
      erase_st_r      <= ER_IDLE;
      erase_busy_o    <= 1'b0;
      erase_req_o     <= 1'b0;
      app_erase_req_o <= 1'b0;
      cfg_unprot_wr_o <= 1'b0;
    end
    else
    begin
      erase_st_r      <= erase_nxt;
      erase_busy_o    <= erase_nxt != ER_IDLE;
      erase_req_o     <= erase_nxt == ER_LOCAL;
      app_erase_req_o <= erase_nxt == ER_APP;
      cfg_unprot_wr_o <= erase_st_r == ER_FINISH;
    end
  end

  // erase keys: consumed when they start an erase
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst || (erase_start && ep_key_hit))
    begin
      ep_key_dbg_r <= WORD_RST;
      ep_key_cpu_r <= WORD_RST;
    end
    else if (!ep_latch_r)
    begin
      if (dbg_wr_ev && dad_s2_r == DBG_EP_KEY_OFS)
        ep_key_dbg_r <= dwd_s2_r;
      if (cw && cpu_addr_i == CPU_EP_KEY_OFS)
        ep_key_cpu_r <= cpu_wdata_i;
    end
  end

  // port and secure keys: survive soft reset
  logic [DW-1:0] port_key_dbg_r, port_key_cpu_r;
  logic [DW-1:0] sec_key_dbg_r, sec_key_cpu_r;
  always_ff @(posedge core_clk_i)
  begin
    if (full_rst)
    begin
      port_key_dbg_r <= WORD_RST;
      port_key_cpu_r <= WORD_RST;
      sec_key_dbg_r  <= WORD_RST;
      sec_key_cpu_r  <= WORD_RST;
    end
    else if (erase_st_r == ER_FINISH)
    begin
      port_key_cpu_r <= KEY_AFTER_ERASE;
      sec_key_cpu_r  <= KEY_AFTER_ERASE;
    end
    else
    begin
      if (!port_latch_r && dbg_wr_ev && dad_s2_r == DBG_PORT_KEY_OFS)
        port_key_dbg_r <= dwd_s2_r;
      if (!port_latch_r && cw && cpu_addr_i == CPU_PORT_KEY_OFS)
        port_key_cpu_r <= cpu_wdata_i;
      if (!sec_latch_r && dbg_wr_ev && dad_s2_r == DBG_SEC_KEY_OFS)
        sec_key_dbg_r <= dwd_s2_r;
      if (!sec_latch_r && cw && cpu_addr_i == CPU_SEC_KEY_OFS)
        sec_key_cpu_r <= cpu_wdata_i;
    end
  end

  // temporary unprotection after an erase
  logic unprot_pend_r, unprot_act_r;
  always_ff @(posedge core_clk_i)
  begin
    if (full_rst)
    begin
      unprot_pend_r <= 1'b0;
      unprot_act_r  <= 1'b0;
    end
    else
    begin
      if (erase_st_r == ER_FINISH)
        unprot_pend_r <= 1'b1;
      if (soft_rst_i && unprot_pend_r)
        unprot_act_r <= 1'b1;
    end
  end

  // access port enables
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
    begin
      bus_ap_en_o     <= 1'b0;
      bus_sec_ap_en_o <= 1'b0;
    end
    else
    begin
      bus_ap_en_o <= unprot_act_r | (~port_cap_r &
        key_ok(port_key_dbg_r, port_key_cpu_r));
      bus_sec_ap_en_o <= unprot_act_r | (~port_cap_r & ~sec_cap_r &
        key_ok(sec_key_dbg_r, sec_key_cpu_r));
    end
  end

  // soft reset request and reset cause
  logic dbg_rst_seen_r;
  logic soft_q_r;
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
      soft_rst_req_o <= 1'b0;
    else
      soft_rst_req_o <= dbg_wr_ev & (dad_s2_r == DBG_SOFT_RST_OFS)
                        & (erase_st_r == ER_IDLE);
  end

  always_ff @(posedge core_clk_i)
  begin
    soft_q_r <= soft_rst_i;
  end

  // cause held over a multi-cycle soft reset, forgotten after it
  always_ff @(posedge core_clk_i)
  begin
    if (full_rst)
    begin
      dbg_rst_seen_r  <= 1'b0;
      rst_cause_dbg_o <= 1'b0;
    end
    else if (soft_rst_i)
      rst_cause_dbg_o <= dbg_rst_seen_r;
    else if (soft_rst_req_o)
      dbg_rst_seen_r <= 1'b1;
    else if (soft_q_r)
      dbg_rst_seen_r <= 1'b0;
  end

  // mailbox in both directions; set wins over clear
  logic [DW-1:0] d2c_word_r, c2d_word_r;
  logic          d2c_pend_r, c2d_pend_r;
  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
    begin
      d2c_word_r <= WORD_RST;
      d2c_pend_r <= 1'b0;
    end
    else if (dbg_wr_ev && dad_s2_r == DBG_OUT_WORD_OFS)
    begin
      d2c_word_r <= dwd_s2_r;
      d2c_pend_r <= 1'b1;
    end
    else if (cr && cpu_addr_i == CPU_IN_WORD_OFS)
      d2c_pend_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (any_rst)
    begin
      c2d_word_r <= WORD_RST;
      c2d_pend_r <= 1'b0;
    end
    else if (cw && cpu_addr_i == CPU_OUT_WORD_OFS)
    begin
      c2d_word_r <= cpu_wdata_i;
      c2d_pend_r <= 1'b1;
    end
    else if (dbg_rd_ev && dad_s2_r == DBG_IN_WORD_OFS)
      c2d_pend_r <= 1'b0;
  end

  // read ports
  logic [DW-1:0] cpu_mux, dbg_mux;
  always_comb
  begin
    cpu_mux = WORD_RST;
    case (cpu_addr_i)
      CPU_IN_WORD_OFS:    cpu_mux = d2c_word_r;
      CPU_IN_FLAG_OFS:    cpu_mux[0] = d2c_pend_r;
      CPU_OUT_WORD_OFS:   cpu_mux = c2d_word_r;
      CPU_OUT_FLAG_OFS:   cpu_mux[0] = c2d_pend_r;
      CPU_PORT_KEY_OFS:   cpu_mux = port_key_cpu_r;
      CPU_SEC_KEY_OFS:    cpu_mux = sec_key_cpu_r;
      CPU_EP_LATCH_OFS:   cpu_mux[0] = ep_latch_r;
      CPU_PORT_LATCH_OFS: cpu_mux[0] = port_latch_r;
      CPU_SEC_LATCH_OFS:  cpu_mux[0] = sec_latch_r;
      CPU_STATUS_OFS:
      begin
        cpu_mux[STAT_PORT_BIT] = ~port_cap_r;
        cpu_mux[STAT_SEC_BIT]  = ~sec_cap_r;
        cpu_mux[STAT_EP_BIT]   = ~ep_cap_r;
      end
      default:            cpu_mux = WORD_RST;
    endcase
  end

  always_comb
  begin
    dbg_mux = WORD_RST;
    case (dad_s2_r)
      DBG_ERASE_STAT_OFS: dbg_mux[0] = erase_busy_o;
      DBG_EP_STAT_OFS:    dbg_mux[0] = ep_cap_r;
      DBG_OUT_FLAG_OFS:   dbg_mux[0] = d2c_pend_r;
      DBG_IN_WORD_OFS:    dbg_mux = c2d_word_r;
      DBG_IN_FLAG_OFS:    dbg_mux[0] = c2d_pend_r;
      DBG_IDENT_OFS:      dbg_mux = IDENT_VALUE;
      default:            dbg_mux = WORD_RST;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      cpu_rdata_o <= WORD_RST;
    else
      cpu_rdata_o <= cr ? cpu_mux : WORD_RST;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      dbg_rdata_o <= WORD_RST;
    else if (dbg_rd_ev)
      dbg_rdata_o <= dbg_mux;
  end

  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (any_rst);

  soft_req_a: assert property (
    dbg_wr_ev && dad_s2_r == DBG_SOFT_RST_OFS && erase_st_r == ER_IDLE
    |=> soft_rst_req_o ##1 !soft_rst_req_o)
    else $error("soft reset request missing");
  rst_cause_a: assert property (
    disable iff (full_rst) soft_rst_i && dbg_rst_seen_r |=> rst_cause_dbg_o)
    else $error("reset cause not recorded");
  erase_busy_a: assert property (
    erase_start |=> erase_busy_o && (erase_req_o || app_erase_req_o))
    else $error("erase did not start");
  erase_end_a: assert property (
    erase_st_r == ER_FINISH |=> !erase_busy_o && cfg_unprot_wr_o
    && port_key_cpu_r == KEY_AFTER_ERASE && sec_key_cpu_r == KEY_AFTER_ERASE)
    else $error("erase finish wrong");
  unprot_soft_a: assert property (
    disable iff (full_rst) $fell(soft_rst_i) && $past(unprot_pend_r)
    |=> bus_ap_en_o && bus_sec_ap_en_o)
    else $error("unprotection not applied");
  app_first_a: assert property (
    IS_SECONDARY && $rose(erase_req_o) |-> $past(app_erase_done_i))
    else $error("application not erased first");
  ep_refuse_a: assert property (
    ep_cap_r && !ep_key_hit && erase_st_r == ER_IDLE |=> !erase_busy_o)
    else $error("protected erase accepted");
  mbox_set_a: assert property (
    cw && cpu_addr_i == CPU_OUT_WORD_OFS |=> c2d_pend_r [*1] ##0
    c2d_word_r == $past(cpu_wdata_i))
    else $error("mailbox flag not set");
  mbox_clr_a: assert property (
    cr && cpu_addr_i == CPU_IN_WORD_OFS
    && !(dbg_wr_ev && dad_s2_r == DBG_OUT_WORD_OFS) |=> !d2c_pend_r)
    else $error("mailbox flag not cleared");
  port_hold_a: assert property (
    port_cap_r && !unprot_act_r |=> !bus_ap_en_o)
    else $error("protected port opened");
  latch_keep_a: assert property (
    port_latch_r && erase_st_r != ER_FINISH |=> $stable(port_key_cpu_r))
    else $error("latched key changed");
  key_diff_a: assert property (
    !key_ok(sec_key_dbg_r, sec_key_cpu_r) && !unprot_act_r
    |=> !bus_sec_ap_en_o)
    else $error("mismatched keys opened port");

endmodule : dcap_top
`default_nettype wire

// >>> testbench/dcap_dbg_model.sv
// debugger probe model: one link-clock frame per register access
// assumes the block samples the link clock with its own core clock
`timescale 1ns/1ns
`default_nettype none
module dcap_dbg_model
  import dcap_pkg::*;
(
  output logic          dbg_clk_o,
  output logic [AW-1:0] dbg_addr_o,
  output logic [DW-1:0] dbg_wdata_o,
  output logic          dbg_wr_o,
  output logic          dbg_rd_o,
  input  wire logic [DW-1:0] dbg_rdata_i
);
  initial
  begin
    dbg_clk_o   = 1'b0;
    dbg_addr_o  = '0;
    dbg_wdata_o = '0;
    dbg_wr_o    = 1'b0;
    dbg_rd_o    = 1'b0;
  end

  // link clock idles low between frames; one request per 48 ns frame
  // debugger key writes share this path
  task automatic xfer(input logic wr, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, output logic [DW-1:0] q);
    dbg_addr_o  = a;
    dbg_wdata_o = d;
    dbg_wr_o    = wr;
    dbg_rd_o    = !wr;
    #16 dbg_clk_o = 1'b1;
    #16 dbg_clk_o = 1'b0;
    // released address and data lines show inverted values, not the last ones
    dbg_wr_o    = 1'b0;
    dbg_rd_o    = 1'b0;
    dbg_addr_o  = ~a;
    dbg_wdata_o = ~d;
    #16 q = dbg_rdata_i;
  endtask : xfer
endmodule : dcap_dbg_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the debug control access port
// assumes dcap_pkg compiled first and the probe model beside it
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import dcap_pkg::*;
;
  logic          core_clk_i = 1'b0;
  logic          sys_rst_i  = 1'b1;
  logic          pin_rst_i  = 1'b0;
  logic          soft_rst_i = 1'b0;
  logic [AW-1:0] cpu_addr   = '0;
  logic [DW-1:0] cpu_wdata  = '0;
  logic          cpu_wr     = 1'b0;
  logic          cpu_rd     = 1'b0;
  logic [DW-1:0] cpu_rdata, dbg_rdata, q;
  logic          dbg_clk, dbg_wr, dbg_rd;
  logic [AW-1:0] dbg_addr;
  logic [DW-1:0] dbg_wdata;
  logic          cfg_port = 1'b0;
  logic          cfg_sec  = 1'b0;
  logic          cfg_ep   = 1'b0;
  logic          er_done  = 1'b0;
  logic          srst_req, cause, er_req, unprot, busy, ap_en, sec_en;
  logic          app_done = 1'b0;
  logic          app_req, sec_er_req;
  logic          saw_srst = 1'b0;
  logic          saw_unprot = 1'b0;
  int            fails = 0;
  int            check_count = 0;
  int            cycles = 0;

  always #2 core_clk_i = ~core_clk_i;

  dcap_top i_dcap_top (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .pin_rst_i(pin_rst_i), .soft_rst_i(soft_rst_i),
    .cpu_addr_i(cpu_addr), .cpu_wdata_i(cpu_wdata),
    .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd), .cpu_rdata_o(cpu_rdata),
    .dbg_clk_i(dbg_clk), .dbg_addr_i(dbg_addr),
    .dbg_wdata_i(dbg_wdata), .dbg_wr_i(dbg_wr), .dbg_rd_i(dbg_rd),
    .dbg_rdata_o(dbg_rdata), .cfg_port_prot_i(cfg_port),
    .cfg_sec_prot_i(cfg_sec), .cfg_erase_prot_i(cfg_ep),
    .erase_done_i(er_done), .app_erase_done_i(1'b0),
    .soft_rst_req_o(srst_req), .rst_cause_dbg_o(cause),
    .erase_req_o(er_req), .app_erase_req_o(),
    .cfg_unprot_wr_o(unprot), .erase_busy_o(busy),
    .bus_ap_en_o(ap_en), .bus_sec_ap_en_o(sec_en));

  // secondary variant sharing all stimulus except its own app_erase_done_i (app_done)
  dcap_top #(.IS_SECONDARY(1'b1)) i_dcap_top_sec (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .pin_rst_i(pin_rst_i), .soft_rst_i(soft_rst_i),
    .cpu_addr_i(cpu_addr), .cpu_wdata_i(cpu_wdata),
    .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd), .cpu_rdata_o(),
    .dbg_clk_i(dbg_clk), .dbg_addr_i(dbg_addr),
    .dbg_wdata_i(dbg_wdata), .dbg_wr_i(dbg_wr), .dbg_rd_i(dbg_rd),
    .dbg_rdata_o(), .cfg_port_prot_i(cfg_port),
    .cfg_sec_prot_i(cfg_sec), .cfg_erase_prot_i(cfg_ep),
    .erase_done_i(er_done), .app_erase_done_i(app_done),
    .soft_rst_req_o(), .rst_cause_dbg_o(),
    .erase_req_o(sec_er_req), .app_erase_req_o(app_req),
    .cfg_unprot_wr_o(), .erase_busy_o(),
    .bus_ap_en_o(), .bus_sec_ap_en_o());

  dcap_dbg_model i_dcap_dbg_model (
    .dbg_clk_o(dbg_clk), .dbg_addr_o(dbg_addr),
    .dbg_wdata_o(dbg_wdata), .dbg_wr_o(dbg_wr), .dbg_rd_o(dbg_rd),
    .dbg_rdata_i(dbg_rdata));

  // sticky monitors for one-cycle pulses
  always @(posedge core_clk_i)
  begin
    if (srst_req === 1'b1) saw_srst <= 1'b1;
    if (unprot === 1'b1) saw_unprot <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk_i);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge core_clk_i);
    cpu_wr    <= 1'b0;
  endtask : cw

  task automatic ck_cr(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge core_clk_i);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge core_clk_i);
    cpu_rd   <= 1'b0;
    #1 check(cpu_rdata, e);
  endtask : ck_cr

  task automatic dw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    i_dcap_dbg_model.xfer(1'b1, a, d, q);
  endtask : dw

  task automatic ck_dr(input logic [AW-1:0] a, input logic [DW-1:0] e);
    i_dcap_dbg_model.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : ck_dr

  // k=0 pin reset, k=1 soft reset
  task automatic hit(input int k);
    @(posedge core_clk_i);
    if (k == 0) pin_rst_i <= 1'b1;
    else soft_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    pin_rst_i  <= 1'b0;
    soft_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask : hit

  task automatic t_mailbox();
    dw(DBG_OUT_WORD_OFS, 32'hC0DE1234);
    ck_cr(CPU_IN_FLAG_OFS, 32'h1);
    ck_dr(DBG_OUT_FLAG_OFS, 32'h1);
    ck_cr(12'h7F0, 32'h0);
    ck_cr(CPU_IN_WORD_OFS, 32'hC0DE1234);
    ck_cr(CPU_IN_FLAG_OFS, 32'h0);
    ck_dr(DBG_OUT_FLAG_OFS, 32'h0);
    cw(CPU_OUT_WORD_OFS, 32'hA5A55A5A);
    ck_cr(CPU_OUT_FLAG_OFS, 32'h1);
    ck_dr(DBG_IN_FLAG_OFS, 32'h1);
    ck_dr(DBG_IN_WORD_OFS, 32'hA5A55A5A);
    ck_dr(DBG_IN_FLAG_OFS, 32'h0);
    ck_cr(CPU_OUT_FLAG_OFS, 32'h0);
  endtask : t_mailbox

  task automatic t_keys();
    cw(CPU_PORT_KEY_OFS, 32'h1234ABCD);
    dw(DBG_PORT_KEY_OFS, 32'h1234ABCE);
    check(ap_en, 1'b0);
    dw(DBG_PORT_KEY_OFS, 32'h1234ABCD);
    check(ap_en, 1'b1);
    cw(CPU_SEC_KEY_OFS, 32'h0F0F0001);
    dw(DBG_SEC_KEY_OFS, 32'h0F0F0001);
    check(sec_en, 1'b1);
    ck_cr(CPU_STATUS_OFS, 32'h7);
    hit(1);
    check(ap_en, 1'b1);
    check(sec_en, 1'b1);
    check(cause, 1'b0);
    hit(0);
    check(ap_en, 1'b0);
    dw(DBG_PORT_KEY_OFS, 32'h0);
    check(ap_en, 1'b0);
    cw(CPU_PORT_LATCH_OFS, 32'h1);
    cw(CPU_PORT_LATCH_OFS, 32'h0);
    ck_cr(CPU_PORT_LATCH_OFS, 32'h1);
    cw(CPU_PORT_KEY_OFS, 32'h55AA0001);
    dw(DBG_PORT_KEY_OFS, 32'h55AA0001);
    check(ap_en, 1'b0);
    cfg_port <= 1'b1;
    hit(0);
    cw(CPU_PORT_KEY_OFS, 32'h55AA0002);
    dw(DBG_PORT_KEY_OFS, 32'h55AA0002);
    check(ap_en, 1'b0);
    ck_cr(CPU_STATUS_OFS, 32'h6);
  endtask : t_keys

  task automatic t_srst();
    dw(DBG_SOFT_RST_OFS, 32'h1);
    check(saw_srst, 1'b1);
    hit(1);
    check(cause, 1'b1);
  endtask : t_srst

  // erase running from the start; finishes and checks the end state
  task automatic finish_erase();
    check(busy, 1'b1);
    check(er_req, 1'b1);
    ck_dr(DBG_ERASE_STAT_OFS, 32'h1);
    saw_srst <= 1'b0;
    dw(DBG_SOFT_RST_OFS, 32'h1);
    check(saw_srst, 1'b0);
    @(posedge core_clk_i);
    er_done <= 1'b1;
    @(posedge core_clk_i);
    er_done <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check(busy, 1'b0);
    check(saw_unprot, 1'b1);
    ck_cr(CPU_PORT_KEY_OFS, KEY_AFTER_ERASE);
    ck_cr(CPU_SEC_KEY_OFS, KEY_AFTER_ERASE);
    ck_dr(DBG_ERASE_STAT_OFS, 32'h0);
  endtask : finish_erase

  task automatic t_erase();
    check(ap_en, 1'b0);
    dw(DBG_ERASE_OFS, 32'h1);
    check(app_req, 1'b1);
    check(sec_er_req, 1'b0);
    @(posedge core_clk_i);
    app_done <= 1'b1;
    @(posedge core_clk_i);
    app_done <= 1'b0;
    #1 check(sec_er_req, 1'b1);
    check(app_req, 1'b0);
    finish_erase();
    hit(1);
    check(ap_en, 1'b1);
    hit(0);
    check(ap_en, 1'b0);
  endtask : t_erase

  task automatic t_eprot();
    cfg_ep <= 1'b1;
    hit(0);
    dw(DBG_ERASE_OFS, 32'h1);
    check(busy, 1'b0);
    cw(CPU_EP_LATCH_OFS, 32'h1);
    cw(CPU_EP_KEY_OFS, 32'h77000077);
    dw(DBG_EP_KEY_OFS, 32'h77000077);
    check(busy, 1'b0);
    hit(1);
    cw(CPU_EP_KEY_OFS, 32'h77000078);
    dw(DBG_EP_KEY_OFS, 32'h77000079);
    check(busy, 1'b0);
    dw(DBG_EP_KEY_OFS, 32'h77000078);
    saw_unprot <= 1'b0;
    finish_erase();
    hit(1);
    check(ap_en, 1'b1);
  endtask : t_eprot

  initial
  begin
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check(busy, 1'b0);
    t_mailbox();
    t_srst();
    t_keys();
    t_erase();
    t_eprot();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
